// ===== hw/lsg_pkg.sv
/*
  constants and carrier types for the lcd-shared gpio ports.
  assumes a byte-wide register port with a 9-bit address.
*/
package lsg_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [8:0] ADDR_C_DATA = 9'h007;
  localparam logic [8:0] ADDR_D_DATA = 9'h008;
  localparam logic [8:0] ADDR_E_DATA = 9'h009;
  localparam logic [8:0] ADDR_C_DIR = 9'h087;
  localparam logic [8:0] ADDR_D_DIR = 9'h088;
  localparam logic [8:0] ADDR_E_DIR = 9'h089;
  localparam logic [8:0] ADDR_SEG_EN = 9'h10d;
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int C_W = 6;
  localparam int D_LOW_W = 5;
  localparam int D_W = 8;
  localparam int E_W = 8;
  localparam logic [5:0] C_DIR_RST = 6'h3f;
  localparam logic [5:0] C_DATA_RST = 6'h00;
  localparam logic [7:0] D_DIR_RST = 8'hff;
  localparam logic [7:0] D_DATA_RST = 8'h00;
  localparam logic [7:0] E_DIR_RST = 8'hff;
  localparam logic [7:0] SEG_EN_RST = 8'hff;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // segment-enable bit positions
  // ----------------------------------------------------------------
  localparam int SEG_EN_LOW_BIT = 0;
  localparam int SEG_EN_B_BIT = 1;
  localparam int SEG_EN_C_BIT = 2;
  localparam int SEG_EN_D_BIT = 6;
  localparam int SEG_EN_UPPER_BIT = 7;
  // ----------------------------------------------------------------
  // lcd segment and common numbering
  // ----------------------------------------------------------------
  localparam int D_UPPER_SEG_BASE = 24;
  localparam int D_UPPER_COM_BASE = 8;
  localparam int E_SEG_BASE = 5;
  localparam int E_TOP_SEG = 27;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lsg_bus_type;
endpackage : lsg_pkg

// ===== hw/lsg_sync3.sv
/*
  three-stage pin synchroniser with agreement filter.
  assumes asynchronous pin inputs and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lsg_sync3 #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= pin_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts once the second and third stages agree
  for (genvar i = 0; i < W; i++)
  begin : g_filt
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        level_ff[i] <= 1'b0;
      else if (s2_ff[i] == s3_ff[i])
        level_ff[i] <= s3_ff[i];
    end
  end

  assign level = level_ff;
endmodule : lsg_sync3
`default_nettype wire

// ===== hw/lsg_pin_drv.sv
/*
  registered pin driver: lcd drive wins over digital drive.
  assumes oe_n low means the pin is driven.
*/
`timescale 1ns/1ps
`default_nettype none
module lsg_pin_drv #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] dig_out,
  input wire logic [W-1:0] dig_in_mode,
  input wire logic [W-1:0] lcd_on,
  input wire logic [W-1:0] lcd_data,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n
);
  logic [W-1:0] out_ff;
  logic [W-1:0] oe_n_ff;

  for (genvar i = 0; i < W; i++)
  begin : g_pin
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        out_ff[i] <= 1'b0;
        oe_n_ff[i] <= 1'b1;
      end
      else if (lcd_on[i])
      begin
        out_ff[i] <= lcd_data[i];
        oe_n_ff[i] <= 1'b0;
      end
      else
      begin
        out_ff[i] <= dig_out[i];
        oe_n_ff[i] <= dig_in_mode[i];
      end
    end
  end

  assign pin_out = out_ff;
  assign pin_oe_n = oe_n_ff;
endmodule : lsg_pin_drv
`default_nettype wire

// ===== hw/lsg_ports.sv
/*
  three gpio ports, two of them shared with lcd drivers,
  with direction and segment-enable registers.
  assumes a cpu register port on ref_clk, pins outside,
  an lcd waveform source and on-chip peripherals.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RQ1 - second port eight bits, schmitt inputs
// RQ2 - second port bits 0-4 gpio or segment
// RQ3 - second port bits 5-7 never outputs
// RQ4 - second direction steers bits 0-4 only
// RQ5 - power-on: lcd drive, segment enables ones
// RQ6 - software clears segment enable for digital
// RQ7 - set segment enable overrides direction bits
// RQ8 - third port input only, lcd shared
// RQ9 - second port pin to segment/common map
// RQ10 - third port segment map, pin7 64-pin absent
// RQ11 - first port bits 6,7 read zero
// RQ12 - first bits 0,1 share timer oscillator
// RQ13 - first bit 2 shares capture/compare
// RQ14 - first bits 3-5 share serial port
// RQ15 - first port reset: latch kept, dir ones
// RQ16 - direction set means input, clear drives
// RQ17 - data read gives pins, write latches
// RQ18 - enabled peripheral overrides first direction
// RQ19 - input-only pins read when enable clear
// RQ20 - core clock access, power-on reset values
module lsg_ports #(
  parameter bit PKG_64PIN = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic warm_rst_n,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] c_pin_in,
  output logic [5:0] c_pin_out,
  output logic [5:0] c_pin_oe_n,
  input wire logic [5:0] c_periph_en,
  input wire logic [5:0] c_periph_drive,
  input wire logic [5:0] c_periph_dout,
  output logic [5:0] c_periph_din,
  input wire logic [7:0] d_pin_in,
  output logic [7:0] d_pin_out,
  output logic [7:0] d_pin_oe_n,
  input wire logic [7:0] e_pin_in,
  output logic [7:0] e_pin_out,
  output logic [7:0] e_pin_oe_n,
  input wire logic [31:0] lcd_seg_data,
  input wire logic [3:0] lcd_com_data,
  input wire logic lcd_com_sel
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lsg_pkg::lsg_bus_type bus;
  logic [5:0] c_data_ff;
  logic [5:0] c_dir_ff;
  logic [7:0] d_data_ff;
  logic [7:0] d_dir_ff;
  logic [7:0] e_dir_ff;
  logic [7:0] seg_en_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [21:0] lvl;
  logic [5:0] c_lvl;
  logic [7:0] d_lvl;
  logic [7:0] e_lvl;
  logic [7:0] d_cov;
  logic [7:0] e_cov;
  logic [7:0] d_lcd;
  logic [7:0] e_lcd;
  logic [7:0] e_on;
  logic [5:0] c_dout;
  logic [5:0] c_dmode;
  logic [7:0] d_dmode;

  assign bus = '{addr: reg_addr, wdata: reg_wdata,
                 wr: reg_wr, rd: reg_rd};

  // ----------------------------------------------------------------
  // pin inputs through the synchroniser
  // ----------------------------------------------------------------
  // all pins model schmitt-buffered inputs; see RQ1
  lsg_sync3 #(.W(22)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_async({e_pin_in, d_pin_in, c_pin_in}),
    .level(lvl)
  );
  assign c_lvl = lvl[5:0];
  assign d_lvl = lvl[13:6];
  assign e_lvl = lvl[21:14];
  assign c_periph_din = c_lvl;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // latch survives warm reset; see RQ15
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      c_data_ff <= lsg_pkg::C_DATA_RST;
    else if (bus.wr && bus.addr == lsg_pkg::ADDR_C_DATA)
      c_data_ff <= bus.wdata[5:0]; // see RQ17
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !warm_rst_n)
      c_dir_ff <= lsg_pkg::C_DIR_RST; // see RQ15
    else if (bus.wr && bus.addr == lsg_pkg::ADDR_C_DIR)
      c_dir_ff <= bus.wdata[5:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !warm_rst_n)
      d_data_ff <= lsg_pkg::D_DATA_RST; // see RQ20
    else if (bus.wr && bus.addr == lsg_pkg::ADDR_D_DATA)
      d_data_ff <= bus.wdata; // see RQ17
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !warm_rst_n)
      d_dir_ff <= lsg_pkg::D_DIR_RST; // see RQ20
    else if (bus.wr && bus.addr == lsg_pkg::ADDR_D_DIR)
      d_dir_ff <= bus.wdata;
  end

  // stored only: the third port never drives digitally
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !warm_rst_n)
      e_dir_ff <= lsg_pkg::E_DIR_RST;
    else if (bus.wr && bus.addr == lsg_pkg::ADDR_E_DIR)
      e_dir_ff <= bus.wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !warm_rst_n)
      seg_en_ff <= lsg_pkg::SEG_EN_RST; // see RQ5
    else if (bus.wr && bus.addr == lsg_pkg::ADDR_SEG_EN)
      seg_en_ff <= bus.wdata; // see RQ6
  end

  // ----------------------------------------------------------------
  // segment-enable coverage per pin
  // ----------------------------------------------------------------
  for (genvar i = 0; i < lsg_pkg::D_W; i++)
  begin : g_dmap
    if (i < lsg_pkg::D_LOW_W)
    begin : g_lo
      assign d_cov[i] = seg_en_ff[lsg_pkg::SEG_EN_LOW_BIT];
      assign d_lcd[i] = lcd_seg_data[i]; // see RQ9
      // direction only counts when digital; see RQ4
      assign d_dmode[i] = d_dir_ff[i];
    end
    else
    begin : g_hi
      assign d_cov[i] = seg_en_ff[lsg_pkg::SEG_EN_UPPER_BIT];
      // pins 5..7 are seg 29..31 or com 3..1; see RQ9
      assign d_lcd[i] = lcd_com_sel
                        ? lcd_com_data[lsg_pkg::D_UPPER_COM_BASE - i]
                        : lcd_seg_data[lsg_pkg::D_UPPER_SEG_BASE + i];
      assign d_dmode[i] = 1'b1; // see RQ3
    end
  end

  for (genvar i = 0; i < lsg_pkg::E_W; i++)
  begin : g_emap
    if (i < 4)
    begin : g_b
      assign e_cov[i] = seg_en_ff[lsg_pkg::SEG_EN_B_BIT];
      assign e_lcd[i] = lcd_seg_data[lsg_pkg::E_SEG_BASE + i];
      assign e_on[i] = e_cov[i];
    end
    else if (i < 7)
    begin : g_c
      assign e_cov[i] = seg_en_ff[lsg_pkg::SEG_EN_C_BIT];
      assign e_lcd[i] = lcd_seg_data[lsg_pkg::E_SEG_BASE + i];
      assign e_on[i] = e_cov[i];
    end
    else
    begin : g_d
      // top pin is seg 27, missing on the small package; see RQ10
      assign e_cov[i] = seg_en_ff[lsg_pkg::SEG_EN_D_BIT];
      assign e_lcd[i] = lcd_seg_data[lsg_pkg::E_TOP_SEG];
      assign e_on[i] = e_cov[i] && !PKG_64PIN;
    end
  end

  // ----------------------------------------------------------------
  // first port peripheral override
  // ----------------------------------------------------------------
  // bit0/1 timer osc, bit2 capture/compare, bit3-5 serial port;
  // the owning peripheral forces direction and data
  for (genvar i = 0; i < lsg_pkg::C_W; i++)
  begin : g_cmux
    assign c_dout[i] = c_periph_en[i] ? c_periph_dout[i]
                                      : c_data_ff[i]; // see RQ12
    assign c_dmode[i] = c_periph_en[i] ? !c_periph_drive[i]
                                       : c_dir_ff[i]; // see RQ18
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // direction 1 leaves the pin undriven; see RQ16
  lsg_pin_drv #(.W(lsg_pkg::C_W)) u_c_drv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .dig_out(c_dout), // see RQ13
    .dig_in_mode(c_dmode), // see RQ14
    .lcd_on(6'h00),
    .lcd_data(6'h00),
    .pin_out(c_pin_out),
    .pin_oe_n(c_pin_oe_n)
  );

  // set enable wins over direction; see RQ7
  lsg_pin_drv #(.W(lsg_pkg::D_W)) u_d_drv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .dig_out(d_data_ff), // see RQ2
    .dig_in_mode(d_dmode),
    .lcd_on(d_cov),
    .lcd_data(d_lcd),
    .pin_out(d_pin_out),
    .pin_oe_n(d_pin_oe_n)
  );

  lsg_pin_drv #(.W(lsg_pkg::E_W)) u_e_drv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .dig_out(8'h00),
    .dig_in_mode(8'hff), // see RQ8
    .lcd_on(e_on),
    .lcd_data(e_lcd),
    .pin_out(e_pin_out),
    .pin_oe_n(e_pin_oe_n)
  );

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = lsg_pkg::RD_ZERO;
    unique case (bus.addr)
      lsg_pkg::ADDR_C_DATA: nxt_rdata = {2'h0, c_lvl}; // see RQ11
      lsg_pkg::ADDR_C_DIR: nxt_rdata = {2'h0, c_dir_ff};
      // upper bits read the pin only as digital input; see RQ19
      lsg_pkg::ADDR_D_DATA: nxt_rdata = d_lvl & ~{d_cov[7:5], 5'h00};
      lsg_pkg::ADDR_D_DIR: nxt_rdata = d_dir_ff;
      lsg_pkg::ADDR_E_DATA: nxt_rdata = e_lvl & ~e_cov;
      lsg_pkg::ADDR_E_DIR: nxt_rdata = e_dir_ff;
      lsg_pkg::ADDR_SEG_EN: nxt_rdata = seg_en_ff;
      default: nxt_rdata = lsg_pkg::RD_ZERO;
    endcase
    if (PKG_64PIN)
      nxt_rdata[7] = nxt_rdata[7] && bus.addr != lsg_pkg::ADDR_E_DATA;
  end

  // data stand only in the cycle after the strobe; see RQ20
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_ff <= lsg_pkg::RD_ZERO;
    else if (bus.rd)
      rdata_ff <= nxt_rdata; // see RQ17
    else
      rdata_ff <= lsg_pkg::RD_ZERO;
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_lcd_low_drive: assert property (@(posedge ref_clk)
    disable iff (!rst_n || !warm_rst_n)
    seg_en_ff[0] |=> !d_pin_oe_n[0] && d_pin_out[0] == $past(lcd_seg_data[0])) // see RQ7
    else $error("low segment pin not lcd driven");

  a_upper_no_out: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !seg_en_ff[7] |=> d_pin_oe_n[7:5] == 3'h7) // see RQ3
    else $error("upper second-port pin driven as digital");

  a_d_dir_follow: assert property (@(posedge ref_clk)
    disable iff (!rst_n || !warm_rst_n)
    !seg_en_ff[0] |=> d_pin_oe_n[4:0] == $past(d_dir_ff[4:0])) // see RQ4
    else $error("second-port direction not applied");

  a_c_upper_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    bus.rd && (bus.addr == lsg_pkg::ADDR_C_DATA || bus.addr == lsg_pkg::ADDR_C_DIR)
    |=> reg_rdata[7:6] == 2'h0) // see RQ11
    else $error("first-port upper bits not zero");

  a_reset_values: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> seg_en_ff == 8'hff && c_dir_ff == 6'h3f
      && d_dir_ff == 8'hff) // see RQ5
    else $error("reset values wrong");

  a_periph_force: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    c_periph_en[2] && c_periph_drive[2]
    |=> !c_pin_oe_n[2] && c_pin_out[2] == $past(c_periph_dout[2])) // see RQ18
    else $error("peripheral did not take the pin");

  a_c_latch_out: assert property (@(posedge ref_clk)
    disable iff (!rst_n || !warm_rst_n)
    !c_periph_en[0] && !c_dir_ff[0]
    |=> !c_pin_oe_n[0] && c_pin_out[0] == $past(c_data_ff[0])) // see RQ16
    else $error("output latch not on pin");

  a_e_read_mask: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    bus.rd && bus.addr == lsg_pkg::ADDR_E_DATA && seg_en_ff[1]
    |=> reg_rdata[3:0] == 4'h0) // see RQ19
    else $error("third port read while lcd owned");

  a_d_write: assert property (@(posedge ref_clk)
    disable iff (!rst_n || !warm_rst_n)
    bus.wr && bus.addr == lsg_pkg::ADDR_D_DATA
    |=> d_data_ff == $past(bus.wdata)) // see RQ17
    else $error("data write not latched");

  a_d_pin_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    bus.rd && bus.addr == lsg_pkg::ADDR_D_DATA
    |=> reg_rdata[4:0] == $past(d_lvl[4:0])) // see RQ1
    else $error("second port read not pin level");

  a_e_input_only: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !e_on[0] |=> e_pin_oe_n[0]) // see RQ8
    else $error("third port pin driven digitally");

  a_small_pkg: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    PKG_64PIN |=> e_pin_oe_n[7]) // see RQ10
    else $error("absent pin driven");
endmodule : lsg_ports
`default_nettype wire

// ===== tb/lsg_pin_model.sv
/*
  pin-side partner: outside drivers and the resolved level of each pin.
  assumes oe_n low means the device drives the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module lsg_pin_model (
  input wire logic [5:0] ext_c,
  input wire logic [7:0] ext_d,
  input wire logic [7:0] ext_e,
  input wire logic [5:0] c_out,
  input wire logic [5:0] c_oe_n,
  input wire logic [7:0] d_out,
  input wire logic [7:0] d_oe_n,
  input wire logic [7:0] e_out,
  input wire logic [7:0] e_oe_n,
  output logic [5:0] c_wire,
  output logic [7:0] d_wire,
  output logic [7:0] e_wire
);
  // ----------------------------------------------------------------
  // pin level: the device wins where it drives, else the outside level
  // ----------------------------------------------------------------
  assign c_wire = (c_oe_n & ext_c) | (~c_oe_n & c_out);
  assign d_wire = (d_oe_n & ext_d) | (~d_oe_n & d_out);
  assign e_wire = (e_oe_n & ext_e) | (~e_oe_n & e_out);
endmodule : lsg_pin_model
`default_nettype wire

// ===== tb/tb_top.sv
/*
  self-checking bench for the lcd-shared gpio ports.
  assumes lsg_pkg, lsg_ports and the pin-side partner model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic warm_rst_n = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] c_pin_in, c_pin_out, c_pin_oe_n, c_periph_din;
  logic [5:0] c_periph_en = 6'h00, c_periph_drive = 6'h00, c_periph_dout = 6'h00;
  logic [7:0] d_pin_in, d_pin_out, d_pin_oe_n, e_pin_in, e_pin_out, e_pin_oe_n;
  logic [31:0] lcd_seg_data = 32'h0000_0000;
  logic [3:0] lcd_com_data = 4'h0;
  logic lcd_com_sel = 1'b0;
  logic [5:0] ext_c = 6'h00;
  logic [7:0] ext_d = 8'h00, ext_e = 8'h00;
  logic [7:0] exp_q[$];
  string name_q[$];
  logic rd_pend = 1'b0;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] g_en[6] = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h80, 8'h38};
  logic [7:0] g_d[6] = '{8'h1f, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00};
  logic [7:0] g_e[6] = '{8'h00, 8'h0f, 8'h70, 8'h80, 8'h00, 8'h00};
  logic [7:0] dd, cd, cr;
  logic [5:0] x_oe, x_out, x_wire;
  logic [7:0] rdata_64, e64_oe_n;

  always #20 ref_clk = ~ref_clk;

  lsg_ports u_lsg_ports (.ref_clk(ref_clk), .rst_n(rst_n), .warm_rst_n(warm_rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .c_pin_in(c_pin_in), .c_pin_out(c_pin_out),
    .c_pin_oe_n(c_pin_oe_n), .c_periph_en(c_periph_en), .c_periph_drive(c_periph_drive),
    .c_periph_dout(c_periph_dout), .c_periph_din(c_periph_din), .d_pin_in(d_pin_in),
    .d_pin_out(d_pin_out), .d_pin_oe_n(d_pin_oe_n), .e_pin_in(e_pin_in),
    .e_pin_out(e_pin_out), .e_pin_oe_n(e_pin_oe_n), .lcd_seg_data(lcd_seg_data),
    .lcd_com_data(lcd_com_data), .lcd_com_sel(lcd_com_sel));

  lsg_pin_model u_lsg_pin_model (.ext_c(ext_c), .ext_d(ext_d), .ext_e(ext_e),
    .c_out(c_pin_out), .c_oe_n(c_pin_oe_n), .d_out(d_pin_out), .d_oe_n(d_pin_oe_n),
    .e_out(e_pin_out), .e_oe_n(e_pin_oe_n), .c_wire(c_pin_in), .d_wire(d_pin_in),
    .e_wire(e_pin_in));

  // small-package variant: third-port top pin absent, pins read straight from outside
  lsg_ports #(.PKG_64PIN(1'b1)) u_lsg_ports_64 (.ref_clk(ref_clk), .rst_n(rst_n),
    .warm_rst_n(warm_rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata_64), .c_pin_in(ext_c), .c_pin_out(), .c_pin_oe_n(),
    .c_periph_en(c_periph_en), .c_periph_drive(c_periph_drive),
    .c_periph_dout(c_periph_dout), .c_periph_din(), .d_pin_in(ext_d), .d_pin_out(),
    .d_pin_oe_n(), .e_pin_in(ext_e), .e_pin_out(), .e_pin_oe_n(e64_oe_n),
    .lcd_seg_data(lcd_seg_data), .lcd_com_data(lcd_com_data), .lcd_com_sel(lcd_com_sel));

  // ----------------------------------------------------------------
  // compare, bus cycles and expected lcd drive
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    exp_q.push_back(e);
    name_q.push_back(n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // waits out the pin synchroniser and the registered drivers
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : settle

  function automatic logic [7:0] d_lcd;
    d_lcd = {lcd_com_sel ? {lcd_com_data[1], lcd_com_data[2], lcd_com_data[3]}
      : lcd_seg_data[31:29], lcd_seg_data[4:0]};
  endfunction : d_lcd

  task results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // read-data watcher: one cycle after each read strobe
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rd_pend && exp_q.size() > 0)
      chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
    rd_pend <= reg_rd;
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h4056e8fb));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    ext_d <= 8'($urandom);
    ext_e <= 8'($urandom) | 8'h01;
    rd(lsg_pkg::ADDR_SEG_EN, 8'hff, "seg_en");
    rd(lsg_pkg::ADDR_C_DIR, 8'h3f, "c_dir");
    rd(lsg_pkg::ADDR_D_DIR, 8'hff, "d_dir");
    rd(lsg_pkg::ADDR_E_DIR, 8'hff, "e_dir");
    rd(9'h0ff, 8'h00, "unmapped");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      lcd_seg_data <= $urandom;
      lcd_com_data <= 4'($urandom);
      lcd_com_sel <= i[0];
      settle();
      chk("d_oe_n", 8'h00, d_pin_oe_n);
      chk("e_oe_n", 8'h00, e_pin_oe_n);
      chk("e64_oe_n", 8'h80, e64_oe_n);
      chk("d_out", d_lcd(), d_pin_out);
      chk("e_out", {lcd_seg_data[27], lcd_seg_data[11:5]}, e_pin_out);
      rd(lsg_pkg::ADDR_E_DATA, 8'h00, "e_data");
      rd(lsg_pkg::ADDR_D_DATA, d_lcd() & 8'h1f, "d_data");
    end
    dd = 8'($urandom);
    wr(lsg_pkg::ADDR_D_DIR, 8'he0);
    wr(lsg_pkg::ADDR_D_DATA, dd);
    settle();
    chk("d_oe_n", 8'h00, d_pin_oe_n);
    wr(lsg_pkg::ADDR_SEG_EN, 8'h00);
    settle();
    chk("d_oe_n", 8'he0, d_pin_oe_n);
    chk("d_out", dd & 8'h1f, d_pin_out & 8'h1f);
    chk("e_oe_n", 8'hff, e_pin_oe_n);
    rd(lsg_pkg::ADDR_D_DATA, {ext_d[7:5], dd[4:0]}, "d_data");
    rd(lsg_pkg::ADDR_E_DATA, ext_e, "e_data");
    #1;
    chk("e64_data", ext_e & 8'h7f, rdata_64);
    wr(lsg_pkg::ADDR_D_DIR, 8'hff);
    settle();
    chk("d_oe_n", 8'hff, d_pin_oe_n);
    rd(lsg_pkg::ADDR_D_DATA, ext_d, "d_data");
    for (int k = 0; k < 6; k++)
    begin
      wr(lsg_pkg::ADDR_SEG_EN, g_en[k]);
      settle();
      chk("d_oe_n", ~g_d[k], d_pin_oe_n);
      chk("e_oe_n", ~g_e[k], e_pin_oe_n);
      chk("d_out", d_lcd() & g_d[k], d_pin_out & g_d[k]);
      chk("e_out", {lcd_seg_data[27], lcd_seg_data[11:5]} & g_e[k], e_pin_out & g_e[k]);
      rd(lsg_pkg::ADDR_E_DATA, ext_e & ~g_e[k], "e_data");
      rd(lsg_pkg::ADDR_SEG_EN, g_en[k], "seg_en");
    end
    for (int j = 0; j < 8; j++)
    begin
      cd = 8'($urandom);
      cr = 8'($urandom);
      wr(lsg_pkg::ADDR_C_DATA, cd);
      wr(lsg_pkg::ADDR_C_DIR, cr);
      @(posedge ref_clk);
      c_periph_en <= (j < 2) ? 6'h00 : 6'($urandom);
      c_periph_drive <= 6'($urandom);
      c_periph_dout <= 6'($urandom);
      ext_c <= 6'($urandom);
      settle();
      x_oe = (c_periph_en & ~c_periph_drive) | (~c_periph_en & cr[5:0]);
      x_out = (c_periph_en & c_periph_dout) | (~c_periph_en & cd[5:0]);
      x_wire = (x_oe & ext_c) | (~x_oe & x_out);
      chk("c_oe_n", {2'b00, x_oe}, {2'b00, c_pin_oe_n});
      chk("c_out", {2'b00, x_out & ~x_oe}, {2'b00, c_pin_out & ~x_oe});
      chk("c_din", {2'b00, x_wire}, {2'b00, c_periph_din});
      rd(lsg_pkg::ADDR_C_DIR, cr & 8'h3f, "c_dir");
      rd(lsg_pkg::ADDR_C_DATA, {2'b00, x_wire}, "c_data");
    end
    @(posedge ref_clk);
    c_periph_en <= 6'h00;
    wr(lsg_pkg::ADDR_C_DATA, 8'h2a);
    @(posedge ref_clk);
    warm_rst_n <= 1'b0;
    @(posedge ref_clk);
    warm_rst_n <= 1'b1;
    rd(lsg_pkg::ADDR_SEG_EN, 8'hff, "seg_en");
    rd(lsg_pkg::ADDR_C_DIR, 8'h3f, "c_dir");
    wr(lsg_pkg::ADDR_C_DIR, 8'h00);
    settle();
    chk("c_out", 8'h2a, {2'b00, c_pin_out});
    repeat (3) @(posedge ref_clk);
    results();
  end
endmodule : tb_top
`default_nettype wire
